// ---- ulp_pkg.sv ----
// Shared constants for the ULPI synchronous and low-power port
package ulp_pkg;
  localparam int         REF_MHZ      = 250;
  localparam int         IFC_MHZ      = 60;
  localparam logic [8:0] ACC_STEP     = 9'(IFC_MHZ);
  localparam logic [8:0] ACC_WRAP     = 9'(REF_MHZ);
  localparam int         STABLE_TICKS = 16;
  localparam logic [4:0] STABLE_LAST  = 5'(STABLE_TICKS - 1);
  localparam int         BUS_W        = 8;
  localparam int         FIFO_DEPTH   = 32;
  localparam int         RX_W         = 9;
  localparam int         REG_WORDS    = 64;
  localparam logic [1:0] CMD_TX       = 2'h1;
  localparam logic [1:0] CMD_REGW     = 2'h2;
  localparam logic [1:0] CMD_REGR     = 2'h3;
  localparam logic [5:0] FUNCTION_CONTROL_REG_ADDR = 6'h04;
  localparam int         SUSP_BIT     = 6;
  localparam logic [7:0] FUNCTION_CONTROL_REG_RST  = 8'h40;
  localparam int         LP_INT_BIT   = 3;
  localparam int         STAT_INT_BIT = 2;
endpackage

// ---- ulp_bus_if.sv ----
// ULPI pins between the PHY end and the link end
`timescale 1ns/1ps
interface ulp_bus_if;
  logic       tick;
  logic       clk_run;
  logic [7:0] data_phy;
  logic       phy_oe;
  logic [7:0] data_link;
  logic       link_oe;
  logic [7:0] data;
  logic       dir;
  logic       nxt;
  logic       stp;

  // Resolved bus level; an undriven bus reads low
  assign data = phy_oe ? data_phy : (link_oe ? data_link : 8'h00);

  modport phy (
    output tick,
    input  clk_run,
    output data_phy,
    output phy_oe,
    input  data,
    output dir,
    output nxt,
    input  stp
  );
  modport link (
    input  tick,
    output clk_run,
    output data_link,
    output link_oe,
    input  data,
    input  dir,
    input  nxt,
    output stp
  );
endinterface : ulp_bus_if

// ---- ulp_fifo.sv ----
// Receive byte FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ulp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  logic         push;
  logic         pop;

  assign out_valid_o = (wr_r != rd_r);
  assign in_ready_o  = (wr_r[AW-1:0] != rd_r[AW-1:0]) ||
                       (wr_r[AW] == rd_r[AW]);
  assign out_data_o  = mem[rd_r[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule : ulp_fifo

// ---- ulp_phy.sv ----
// PHY end of the ULPI port: synchronous and low-power modes
`timescale 1ns/1ps
// Overview of operation
// - Power-up waits stable clock, then synchronous mode
// - Interface clock at 60 MHz when reference present
// - Link holds idle data bus low
// - Nonzero byte starts transfer; zero is idle
// - One turnaround cycle per DIR change, ignored
// - DIR low unless PHY has data; also held high in the power-up wait and low power
// - NXT high means data, low means RXCMD
// - Register read data uses RXCMD slot, NXT low
// - DIR held high throughout low-power mode
// - Link pulses STP one cycle after last byte
// - STP during DIR high aborts PHY transfer
// - Abort drops DIR on very next cycle
// - STP held high wakes to synchronous mode
// - NXT with DIR low requests next byte
// - NXT with DIR high only for data
// - NXT unused in low-power mode
// - Suspend bit written zero enters low power
// - STP in low power is exit request
// - Link restarts clock before exit STP
// - After wake, RXCMD if interrupt still present
// - Data lines 0,1 carry live line state
// - Data line 3 flags unmasked interrupt
// - Reserved data lines driven low
module ulp_phy (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  ulp_bus_if.phy          bus,
  input  wire logic       ref_present_i,
  input  wire logic [1:0] line_state_i,
  input  wire logic       int_level_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_last_i,
  output logic            rx_ready_o,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  output logic            tx_last_o,
  output logic            suspended_o
);
  typedef enum logic [2:0] {
    P_BOOT, P_IDLE, P_RECV, P_RDACK, P_TURN_UP, P_SEND, P_TURN_DN, P_LP
  } ulp_phy_st_t;

  ulp_phy_st_t st_r;
  logic [3:0]  s1_r;
  logic [3:0]  s2_r;
  logic [8:0]  acc_r;
  logic        tick_r;
  logic [4:0]  boot_cnt_r;
  logic        dir_r;
  logic        nxt_r;
  logic [7:0]  dout_r;
  logic        doe_r;
  logic        lp_r;
  logic        first_r;
  logic [1:0]  cmd_r;
  logic [5:0]  addr_r;
  logic [7:0]  wdata_r;
  logic        lp_go_r;
  logic        rd_go_r;
  logic        last_r;
  logic        int_flag_r;
  logic        int_prev_r;
  logic        wake_pend_r;
  logic [7:0]  sent_r;
  logic [7:0]  regs [ulp_pkg::REG_WORDS];
  logic [8:0]  acc_nxt;
  logic        ref_ok;
  logic        int_s;
  logic [1:0]  ls_s;
  logic [7:0]  status;
  logic        stat_pend;
  logic        f_valid;
  logic [8:0]  f_data;
  logic        f_pop;
  logic        tick;
  logic        int_rise;
  logic        lp_clr;

  assign ref_ok    = s2_r[3];
  assign int_s     = s2_r[2];
  assign ls_s      = s2_r[1:0];
  assign tick      = tick_r;
  assign status    = {5'h00, int_s, ls_s};
  assign stat_pend = (status != sent_r) || wake_pend_r;
  assign int_rise  = int_s && !int_prev_r;
  assign lp_clr    = tick && (st_r == P_TURN_UP) && lp_go_r;
  assign f_pop     = tick && (st_r == P_SEND) && !bus.stp && !last_r;

  ulp_fifo #(
    .W     (ulp_pkg::RX_W),
    .DEPTH (ulp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rx_valid_i),
    .in_data_i   ({rx_last_i, rx_data_i}),
    .in_ready_o  (rx_ready_o),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_pop)
  );

  // Low-power mapping is combinational from the line receiver
  assign bus.data_phy = lp_r ? {4'h0, int_flag_r, 1'b0, line_state_i}
                             : dout_r;
  assign bus.phy_oe   = doe_r;
  assign bus.dir      = dir_r;
  assign bus.nxt      = nxt_r;
  assign bus.tick     = tick_r;
  assign suspended_o  = lp_r;

  // Pin synchronisers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= {ref_present_i, int_level_i, line_state_i};
      s2_r <= s1_r;
    end
  end

  // Fractional divider: tick is the interface clock rising edge
  assign acc_nxt = acc_r + ulp_pkg::ACC_STEP;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r  <= 9'h000;
      tick_r <= 1'b0;
    end else if (ref_ok && bus.clk_run) begin
      tick_r <= (acc_nxt >= ulp_pkg::ACC_WRAP);
      acc_r  <= (acc_nxt >= ulp_pkg::ACC_WRAP) ?
                acc_nxt - ulp_pkg::ACC_WRAP : acc_nxt;
    end else begin
      tick_r <= 1'b0;
    end
  end

  // Interrupt event flag for low-power data line 3
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_prev_r <= 1'b0;
      int_flag_r <= 1'b0;
    end else begin
      int_prev_r <= int_s;
      if (int_rise) begin
        int_flag_r <= 1'b1;
      end else if (lp_clr) begin
        int_flag_r <= 1'b0;
      end
    end
  end

  // Register space, written by register-write commands
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ulp_pkg::REG_WORDS; i++) begin
        regs[i] <= (i == int'(ulp_pkg::FUNCTION_CONTROL_REG_ADDR)) ?
                   ulp_pkg::FUNCTION_CONTROL_REG_RST : 8'h00;
      end
    end else if (tick) begin
      if (st_r == P_RECV && bus.stp && cmd_r == ulp_pkg::CMD_REGW) begin
        regs[addr_r] <= wdata_r;
      end else if (st_r == P_LP && bus.stp) begin
        regs[ulp_pkg::FUNCTION_CONTROL_REG_ADDR][ulp_pkg::SUSP_BIT] <= 1'b1;
      end
    end
  end

  // Interface sequencer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r        <= P_BOOT;
      boot_cnt_r  <= 5'h00;
      dir_r       <= 1'b1;
      nxt_r       <= 1'b0;
      dout_r      <= 8'h00;
      doe_r       <= 1'b0;
      lp_r        <= 1'b0;
      first_r     <= 1'b0;
      cmd_r       <= 2'h0;
      addr_r      <= 6'h00;
      wdata_r     <= 8'h00;
      lp_go_r     <= 1'b0;
      rd_go_r     <= 1'b0;
      last_r      <= 1'b0;
      wake_pend_r <= 1'b0;
      sent_r      <= 8'h00;
      tx_valid_o  <= 1'b0;
      tx_data_o   <= 8'h00;
      tx_last_o   <= 1'b0;
    end else begin
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
      if (tick) begin
        unique case (st_r)
          P_BOOT: begin
            boot_cnt_r <= boot_cnt_r + 5'h01;
            if (boot_cnt_r == ulp_pkg::STABLE_LAST) begin
              dir_r <= 1'b0;
              st_r  <= P_TURN_DN;
            end
          end
          P_IDLE: begin
            if (bus.data != 8'h00) begin
              cmd_r   <= bus.data[7:6];
              addr_r  <= bus.data[5:0];
              nxt_r   <= 1'b1;
              first_r <= 1'b1;
              st_r    <= (bus.data[7:6] == ulp_pkg::CMD_REGR) ?
                         P_RDACK : P_RECV;
            end else if (f_valid || stat_pend) begin
              dir_r <= 1'b1;
              st_r  <= P_TURN_UP;
            end
          end
          P_RECV: begin
            first_r <= 1'b0;
            if (bus.stp) begin
              nxt_r     <= 1'b0;
              tx_last_o <= (cmd_r != ulp_pkg::CMD_REGW);
              if (cmd_r == ulp_pkg::CMD_REGW &&
                  addr_r == ulp_pkg::FUNCTION_CONTROL_REG_ADDR &&
                  !wdata_r[ulp_pkg::SUSP_BIT]) begin
                lp_go_r <= 1'b1;
                dir_r   <= 1'b1;
                st_r    <= P_TURN_UP;
              end else begin
                st_r <= P_IDLE;
              end
            end else if (!first_r) begin
              wdata_r    <= bus.data;
              tx_data_o  <= bus.data;
              tx_valid_o <= (cmd_r != ulp_pkg::CMD_REGW);
            end
          end
          P_RDACK: begin
            nxt_r   <= 1'b0;
            dir_r   <= 1'b1;
            rd_go_r <= 1'b1;
            st_r    <= P_TURN_UP;
          end
          P_TURN_UP: begin
            doe_r <= 1'b1;
            if (lp_go_r) begin
              lp_go_r <= 1'b0;
              lp_r    <= 1'b1;
              st_r    <= P_LP;
            end else if (rd_go_r) begin
              rd_go_r <= 1'b0;
              dout_r  <= regs[addr_r];
              nxt_r   <= 1'b0;
              last_r  <= 1'b1;
              st_r    <= P_SEND;
            end else begin
              dout_r      <= status;
              sent_r      <= status;
              wake_pend_r <= 1'b0;
              nxt_r       <= 1'b0;
              last_r      <= !f_valid;
              st_r        <= P_SEND;
            end
          end
          P_SEND: begin
            if (bus.stp || last_r) begin
              dir_r <= 1'b0;
              doe_r <= 1'b0;
              nxt_r <= 1'b0;
              st_r  <= P_TURN_DN;
            end else if (f_valid) begin
              dout_r <= f_data[7:0];
              nxt_r  <= 1'b1;
              last_r <= f_data[8];
            end else begin
              dout_r <= status;
              sent_r <= status;
              nxt_r  <= 1'b0;
            end
          end
          P_TURN_DN: begin
            st_r <= P_IDLE;
          end
          P_LP: begin
            nxt_r <= 1'b0;
            if (bus.stp) begin
              lp_r        <= 1'b0;
              dir_r       <= 1'b0;
              doe_r       <= 1'b0;
              wake_pend_r <= int_flag_r && int_s;
              st_r        <= P_TURN_DN;
            end
          end
        endcase
      end
    end
  end
endmodule : ulp_phy

// ---- ulp_link.sv ----
// Link end of the ULPI port
`timescale 1ns/1ps
module ulp_link (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  ulp_bus_if.link         bus,
  input  wire logic       req_valid_i,
  input  wire logic [1:0] req_kind_i,
  input  wire logic [5:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic            req_ack_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            tx_ack_o,
  input  wire logic       abort_i,
  input  wire logic       clk_stop_i,
  input  wire logic       wake_i,
  output logic            rx_valid_o,
  output logic            rxcmd_valid_o,
  output logic            rd_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            lp_o
);
  typedef enum logic [2:0] {
    L_IDLE, L_CMD, L_DATA, L_STP, L_RDW, L_LP, L_WAKE, L_EXIT
  } ulp_link_st_t;

  ulp_link_st_t st_r;
  logic         dir_q_r;
  logic         oe_r;
  logic [7:0]   dout_r;
  logic         stp_r;
  logic         run_r;
  logic         last_r;
  logic         lp_next_r;
  logic [1:0]   kind_r;
  logic         rx_ok;

  assign bus.data_link = dout_r;
  assign bus.link_oe   = oe_r;
  assign bus.stp       = stp_r;
  assign bus.clk_run   = run_r;
  assign rx_ok = bus.dir && dir_q_r && st_r != L_LP && st_r != L_WAKE
                 && st_r != L_EXIT;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r          <= L_IDLE;
      dir_q_r       <= 1'b1;
      oe_r          <= 1'b0;
      dout_r        <= 8'h00;
      stp_r         <= 1'b0;
      run_r         <= 1'b1;
      last_r        <= 1'b0;
      lp_next_r     <= 1'b0;
      kind_r        <= 2'h0;
      req_ack_o     <= 1'b0;
      tx_ack_o      <= 1'b0;
      rx_valid_o    <= 1'b0;
      rxcmd_valid_o <= 1'b0;
      rd_valid_o    <= 1'b0;
      rx_data_o     <= 8'h00;
      lp_o          <= 1'b0;
    end else begin
      req_ack_o     <= 1'b0;
      tx_ack_o      <= 1'b0;
      rx_valid_o    <= 1'b0;
      rxcmd_valid_o <= 1'b0;
      rd_valid_o    <= 1'b0;
      if (st_r == L_LP) begin
        oe_r  <= 1'b0;
        run_r <= !clk_stop_i || wake_i;
        if (wake_i) begin
          run_r <= 1'b1;
          st_r  <= L_WAKE;
        end
      end else if (bus.tick) begin
        dir_q_r <= bus.dir;
        oe_r    <= !bus.dir && !dir_q_r;
        if (rx_ok) begin
          rx_data_o     <= bus.data;
          rx_valid_o    <= bus.nxt;
          rd_valid_o    <= !bus.nxt && st_r == L_RDW;
          rxcmd_valid_o <= !bus.nxt && st_r != L_RDW;
        end
        unique case (st_r)
          L_IDLE: begin
            dout_r <= 8'h00;
            if (rx_ok && abort_i) begin
              stp_r <= 1'b1;
              st_r  <= L_STP;
            end else if (!bus.dir && !dir_q_r && req_valid_i &&
                         req_kind_i != 2'h0) begin
              dout_r    <= {req_kind_i, req_addr_i};
              kind_r    <= req_kind_i;
              lp_next_r <= req_kind_i == ulp_pkg::CMD_REGW &&
                           req_addr_i == ulp_pkg::FUNCTION_CONTROL_REG_ADDR &&
                           !req_wdata_i[ulp_pkg::SUSP_BIT];
              req_ack_o <= 1'b1;
              st_r      <= L_CMD;
            end
          end
          L_CMD: begin
            if (bus.nxt && !bus.dir) begin
              if (kind_r == ulp_pkg::CMD_REGR) begin
                dout_r <= 8'h00;
                st_r   <= L_RDW;
              end else if (kind_r == ulp_pkg::CMD_REGW) begin
                dout_r <= req_wdata_i;
                last_r <= 1'b1;
                st_r   <= L_DATA;
              end else begin
                dout_r   <= tx_data_i;
                last_r   <= tx_last_i || !tx_valid_i;
                tx_ack_o <= tx_valid_i;
                st_r     <= L_DATA;
              end
            end
          end
          L_DATA: begin
            if (bus.nxt) begin
              if (last_r) begin
                dout_r <= 8'h00;
                stp_r  <= 1'b1;
                st_r   <= L_STP;
              end else begin
                dout_r   <= tx_data_i;
                last_r   <= tx_last_i || !tx_valid_i;
                tx_ack_o <= tx_valid_i;
              end
            end
          end
          L_STP: begin
            stp_r     <= 1'b0;
            lp_next_r <= 1'b0;
            lp_o      <= lp_next_r;
            st_r      <= lp_next_r ? L_LP : L_IDLE;
          end
          L_RDW: begin
            if (rx_ok && !bus.nxt) begin
              st_r <= L_IDLE;
            end
          end
          L_WAKE: begin
            stp_r <= 1'b1;
            st_r  <= L_EXIT;
          end
          L_EXIT: begin
            if (!bus.dir) begin
              stp_r <= 1'b0;
              lp_o  <= 1'b0;
              st_r  <= L_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule : ulp_link

// ---- ulp_props.sv ----
// Concurrent checks on the ULPI pins between PHY and link
`timescale 1ns/1ps
module ulp_props (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       tick,
  input wire logic       clk_run,
  input wire logic [7:0] data_phy,
  input wire logic       phy_oe,
  input wire logic [7:0] data_link,
  input wire logic       link_oe,
  input wire logic [7:0] data,
  input wire logic       dir,
  input wire logic       nxt,
  input wire logic       stp
);
  logic       dir_r;
  logic       nxt_r;
  logic       stp_r;
  logic [7:0] dat_r;
  logic       seen_r;
  logic [3:0] gap_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Pin values at the previous tick
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_r <= 1'b1;
      nxt_r <= 1'b0;
      stp_r <= 1'b0;
      dat_r <= 8'h00;
    end else if (tick) begin
      dir_r <= dir;
      nxt_r <= nxt;
      stp_r <= stp;
      dat_r <= data;
    end
  end

  // Idle cycles since the last tick
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
      gap_r  <= 4'h0;
    end else if (tick) begin
      seen_r <= 1'b1;
      gap_r  <= 4'h0;
    end else if (!clk_run) begin
      seen_r <= 1'b0;
      gap_r  <= 4'h0;
    end else if (seen_r) begin
      gap_r  <= gap_r + 4'h1;
    end
  end

  AST_ONE_OWNER: assert property (!(phy_oe && link_oe))
    else $error("both ends drive the bus");
  AST_PHY_DRIVES_UP: assert property (phy_oe |-> dir)
    else $error("phy drives bus with dir low");
  AST_TURN_NO_NXT: assert property (tick && dir && !dir_r |-> !nxt)
    else $error("nxt high in turnaround");
  AST_ABORT_DROP: assert property (tick && dir && dir_r && stp |=> !dir)
    else $error("dir kept after stp");
  AST_STP_ONE: assert property (tick && stp && !dir && !dir_r |-> !stp_r)
    else $error("stp longer than one tick");
  AST_STOP_ENDS_NXT: assert property (tick && stp_r && !dir_r && !dir |-> !nxt)
    else $error("nxt after stp");
  AST_NXT_CAUSE: assert property (
    tick && !dir && !dir_r && nxt && !nxt_r |-> dat_r != 8'h00)
    else $error("nxt without command");
  AST_TICK_ONLY: assert property (!tick |=> $stable(dir) && $stable(nxt))
    else $error("dir or nxt moved off tick");
  AST_TICK_RATE: assert property (gap_r <= 4'h4)
    else $error("interface clock too slow");
  AST_TICK_HALT: assert property (!clk_run [*3] |-> !tick)
    else $error("tick while clock stopped");
endmodule // ulp_props

// ---- tb.sv ----
// Self-checking bench for the ULPI PHY and link pair
`timescale 1ns/1ps
module tb;
  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [1:0] ls = 2'h0;
  logic       intl = 1'b0, rxv = 1'b0, rxl = 1'b0, rxr;
  logic [7:0] rxd = 8'h00, ptd, lkd;
  logic       ptv, ptl, susp, rqv = 1'b0, rqa, txv = 1'b0, txl = 1'b0;
  logic [1:0] rqk = 2'h0;
  logic [5:0] rqa_d = 6'h00;
  logic [7:0] rqw = 8'h00, txd = 8'h00;
  logic       txa, abt = 1'b0, cstop = 1'b0, wake = 1'b0;
  logic       lrx, lcm, lrd, lp;
  logic       refp = 1'b0;
  logic [7:0] rxq[$], rdq[$], cmq[$], txq[$];
  int         fails = 0, n_tests = 0, cyc = 0, nlast = 0, nt = 0;

  ulp_bus_if u_ulp_bus_if ();
  ulp_phy u_ulp_phy (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus(u_ulp_bus_if), .ref_present_i(refp), .line_state_i(ls),
    .int_level_i(intl), .rx_valid_i(rxv), .rx_data_i(rxd),
    .rx_last_i(rxl), .rx_ready_o(rxr), .tx_valid_o(ptv),
    .tx_data_o(ptd), .tx_last_o(ptl), .suspended_o(susp));
  ulp_link u_ulp_link (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .bus(u_ulp_bus_if), .req_valid_i(rqv), .req_kind_i(rqk),
    .req_addr_i(rqa_d), .req_wdata_i(rqw), .req_ack_o(rqa),
    .tx_valid_i(txv), .tx_data_i(txd), .tx_last_i(txl), .tx_ack_o(txa),
    .abort_i(abt), .clk_stop_i(cstop), .wake_i(wake), .rx_valid_o(lrx),
    .rxcmd_valid_o(lcm), .rd_valid_o(lrd), .rx_data_o(lkd), .lp_o(lp));
  ulp_props u_ulp_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .tick(u_ulp_bus_if.tick), .clk_run(u_ulp_bus_if.clk_run),
    .data_phy(u_ulp_bus_if.data_phy), .phy_oe(u_ulp_bus_if.phy_oe),
    .data_link(u_ulp_bus_if.data_link), .link_oe(u_ulp_bus_if.link_oe),
    .data(u_ulp_bus_if.data), .dir(u_ulp_bus_if.dir),
    .nxt(u_ulp_bus_if.nxt), .stp(u_ulp_bus_if.stp));

  always #2 ref_clk_i = ~ref_clk_i;

  // Output capture and run limit
  always @(negedge ref_clk_i) begin
    if (lrx === 1'b1) rxq.push_back(lkd);
    if (lrd === 1'b1) rdq.push_back(lkd);
    if (lcm === 1'b1) cmq.push_back(lkd);
    if (ptv === 1'b1) txq.push_back(ptd);
    if (ptl === 1'b1) nlast++;
    if (u_ulp_bus_if.tick === 1'b1) nt++;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim;
    end
  end

  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task end_sim;
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task do_reset;
    int t0;
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    refp <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t0 = nt;
    repeat (10) @(negedge ref_clk_i);
    chk("ref_gate", 8'(nt - t0), 8'h00);
    @(posedge ref_clk_i);
    refp <= 1'b1;
    while (u_ulp_bus_if.dir !== 1'b0) @(negedge ref_clk_i);
    chk("boot_ticks", 8'(nt - t0 >= ulp_pkg::STABLE_TICKS), 8'h01);
    t0 = nt;
    repeat (250) @(negedge ref_clk_i);
    chk("tick_rate", 8'(nt - t0), 8'h3C);
    repeat (40) @(negedge ref_clk_i);
  endtask

  task automatic req(input logic [1:0] k, input logic [5:0] a,
                     input logic [7:0] w);
    @(posedge ref_clk_i);
    rqv <= 1'b1;
    rqk <= k;
    rqa_d <= a;
    rqw <= w;
    do @(negedge ref_clk_i); while (rqa !== 1'b1);
    @(posedge ref_clk_i);
    rqv <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
  endtask

  task automatic push(input int cnt, output bit full);
    int n;
    n = 0;
    full = 0;
    do begin
      @(posedge ref_clk_i);
      rxv <= 1'b1;
      rxd <= 8'(n);
      rxl <= (n == cnt - 1);
      @(negedge ref_clk_i);
      if (rxr === 1'b1) n++;
      else full = 1;
    end while (n < cnt);
    @(posedge ref_clk_i);
    rxv <= 1'b0;
    rxl <= 1'b0;
  endtask

  task t_reg;
    rdq.delete();
    req(2'h3, ulp_pkg::FUNCTION_CONTROL_REG_ADDR, 8'h00);
    while (rdq.size() == 0) @(negedge ref_clk_i);
    chk("function_control_reg", rdq.pop_front(), ulp_pkg::FUNCTION_CONTROL_REG_RST);
    req(2'h2, 6'h3F, 8'hA5);
    req(2'h3, 6'h3F, 8'h00);
    while (rdq.size() == 0) @(negedge ref_clk_i);
    chk("reg_rw", rdq.pop_front(), 8'hA5);
  endtask

  task t_tx;
    txq.delete();
    nlast = 0;
    fork
      req(2'h1, 6'h01, 8'h00);
      for (int i = 0; i < 3; i++) begin
        @(posedge ref_clk_i);
        txv <= 1'b1;
        txd <= 8'hC1 + 8'(i);
        txl <= (i == 2);
        do @(negedge ref_clk_i); while (txa !== 1'b1);
      end
    join
    @(posedge ref_clk_i);
    txv <= 1'b0;
    txl <= 1'b0;
    while (nlast == 0) @(negedge ref_clk_i);
    chk("tx_count", 8'(txq.size()), 8'h03);
    for (int i = 0; i < 3; i++) begin
      chk("tx_byte", txq[i], 8'hC1 + 8'(i));
    end
  endtask

  task t_rx;
    bit full;
    rxq.delete();
    push(60, full);
    chk("fifo_refused", 8'(full), 8'h01);
    while (rxq.size() < 60) @(negedge ref_clk_i);
    for (int i = 0; i < 60; i++) begin
      chk("rx_byte", rxq[i], 8'(i));
    end
    repeat (40) @(negedge ref_clk_i);
    chk("fifo_empty", {u_ulp_bus_if.dir, rxr}, 8'h01);
  endtask

  task t_lp;
    int t0;
    req(2'h2, ulp_pkg::FUNCTION_CONTROL_REG_ADDR, 8'h00);
    while (lp !== 1'b1) @(negedge ref_clk_i);
    repeat (20) @(negedge ref_clk_i);
    chk("lp_susp", susp, 8'h01);
    chk("lp_dir", {u_ulp_bus_if.dir, u_ulp_bus_if.nxt}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      ls <= 2'(i);
      @(negedge ref_clk_i);
      chk("lp_map", u_ulp_bus_if.data, 8'(i));
    end
    @(posedge ref_clk_i);
    intl <= 1'b1;
    repeat (30) @(negedge ref_clk_i);
    chk("lp_int", u_ulp_bus_if.data, 8'h0B);
    @(posedge ref_clk_i);
    cstop <= 1'b1;
    repeat (5) @(negedge ref_clk_i);
    t0 = nt;
    repeat (20) @(negedge ref_clk_i);
    chk("clk_stopped", 8'(nt - t0), 8'h00);
    cmq.delete();
    @(posedge ref_clk_i);
    cstop <= 1'b0;
    wake <= 1'b1;
    while (lp !== 1'b0) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    wake <= 1'b0;
    while (cmq.size() == 0) @(negedge ref_clk_i);
    chk("wake_susp", susp, 8'h00);
    chk("wake_rxcmd", cmq[0], 8'h07);
  endtask

  task t_abort;
    bit full;
    rxq.delete();
    @(posedge ref_clk_i);
    abt <= 1'b1;
    push(20, full);
    while (u_ulp_bus_if.dir !== 1'b0) @(negedge ref_clk_i);
    chk("abort_short", 8'(rxq.size() < 20), 8'h01);
    @(posedge ref_clk_i);
    abt <= 1'b0;
    do_reset;
  endtask

  initial begin
    do_reset;
    t_reg;
    t_tx;
    t_rx;
    t_lp;
    t_abort;
    end_sim;
  end
endmodule // tb
